// *** rpd_cfg.svh ***
// rpd_cfg.svh: offsets, field positions and constants of the radar pulse detector
`ifndef RPD_CFG_SVH
`define RPD_CFG_SVH
`define RPD_SW 16
`define RPD_AW 6
`define RPD_NCH 4
`define RPD_REG_CTRL 6'h00
`define RPD_REG_THRESH 6'h04
`define RPD_REG_STATUS 6'h08
`define RPD_REG_SEL 6'h0C
`define RPD_REG_COUNT 6'h10
`define RPD_REG_PIDX 6'h14
`define RPD_REG_PVAL 6'h18
`define RPD_REG_AVG 6'h1C
`define RPD_REG_THR_USED 6'h20
`define RPD_CTRL_EN 0
`define RPD_CTRL_MODE_LO 1
`define RPD_CTRL_MODE_HI 3
`define RPD_MODE_FAST 2
`define RPD_SEL_CH_HI 1
`define RPD_SEL_NUM_LO 16
`define RPD_THRESH_RST 16'h0000
`define RPD_NAN 32'h7FC00000
`define RPD_T_MIN_SLOW_NS 2000
`define RPD_T_MIN_FAST_NS 500
`define RPD_DIV_STEPS 6'h20
`endif

// *** rpd_host_model.sv ***
// rpd_host_model.sv: avalon master standing in for host software
`timescale 1ns/100ps
`default_nettype none
module rpd_host_model (
	input wire logic i_ref_clk,
	input wire logic i_wait,
	input wire logic [31:0] i_rdata,
	output rpd_pkg::rpd_avs_req_s o_req
);
	import rpd_pkg::*;
	initial o_req = '0;
	// request held until the edge that samples waitrequest low, then one idle edge
	task xfer(input logic w, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
		o_req <= '{read: !w, write: w, address: a, writedata: wd};
		do @(posedge i_ref_clk); while (i_wait !== 1'b0);
		rd = i_rdata;
		o_req <= '0;
		@(posedge i_ref_clk);
	endtask
endmodule
`default_nettype wire

// *** rpd_pkg.sv ***
// rpd_pkg: shared types of the radar pulse detector
`include "rpd_cfg.svh"
package rpd_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_MINMAX = 5'h02,
		ST_SCAN = 5'h04,
		ST_POST = 5'h08,
		ST_DIVIDE = 5'h10
	} rpd_state_e;
	typedef struct packed {
		logic frame_first;
		logic [`RPD_NCH-1:0][`RPD_SW-1:0] ch;
	} rpd_smp_s;
	typedef struct packed {
		logic valid;
		logic wave_first;
		rpd_smp_s smp;
	} rpd_cap_s;
	typedef struct packed {
		logic read;
		logic write;
		logic [`RPD_AW-1:0] address;
		logic [31:0] writedata;
	} rpd_avs_req_s;
	typedef struct packed {
		logic ok;
		logic [31:0] num;
		logic [15:0] den;
	} rpd_close_s;
endpackage

// *** rpd_radar_pulse_detector.sv ***
// rpd_radar_pulse_detector: frame pulse scan with an Avalon-MM register slave
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "rpd_cfg.svh"
module rpd_radar_pulse_detector #(
	parameter int DEPTH = 1024,
	parameter int MAXP = 64,
	parameter int SMP_NS_SLOW = 500,
	parameter int SMP_NS_FAST = 125
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire rpd_pkg::rpd_avs_req_s i_avs,
	output logic o_avs_waitrequest,
	output logic [31:0] o_avs_readdata,
	input wire rpd_pkg::rpd_cap_s i_cap,
	input wire logic i_capture_done,
	input wire logic [15:0] i_trig_pos,
	output logic o_busy,
	output logic o_results_valid
);
	import rpd_pkg::*;
	localparam int MAW = $clog2(DEPTH);
	localparam int PW = (MAXP > 1) ? $clog2(MAXP) : 1;
	localparam logic [15:0] MINW_SLOW = 16'(`RPD_T_MIN_SLOW_NS / SMP_NS_SLOW + 1);
	localparam logic [15:0] MINW_FAST = 16'(`RPD_T_MIN_FAST_NS / SMP_NS_FAST + 1);
	localparam logic [15:0] MAXP_W = 16'(MAXP);
	localparam logic [15:0] DEPTH_W = 16'(DEPTH);

	if (DEPTH < 4 || DEPTH > 32768 || (DEPTH & (DEPTH - 1)) != 0 || MAXP < 1 ||
		MAXP > 32767 || SMP_NS_SLOW < 1 || SMP_NS_FAST < 1) begin : g_chk
		$error("rpd: unsupported parameter set");
	end

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] f_max(input logic [15:0] a, input logic [15:0] b);
		return (a > b) ? a : b;
	endfunction
	function automatic logic [15:0] f_mid(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[16:1];
	endfunction
	// last is the sample that ends the pulse; lead and tail mark cut pulses
	function automatic rpd_close_s f_close(input logic [15:0] n, input logic [31:0] sum,
		input logic [15:0] first, input logic [15:0] last, input logic [15:0] pmx,
		input logic lead, input logic tail, input logic [15:0] minw);
		rpd_close_s r;
		r.ok = (n >= 16'h0002);
		r.den = n - 16'h0001;
		r.num = sum - {16'h0000, first};
		if (lead) begin
			r.num = sum - {16'h0000, last};
		end else if (!tail) begin
			r.ok = (n >= minw);
			if (n <= 16'h0002) begin
				r.num = {16'h0000, pmx};
				r.den = 16'h0001;
			end else begin
				r.num = sum - {16'h0000, first} - {16'h0000, last};
				r.den = n - 16'h0002;
			end
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// storage and state
	// ---------------------------------------------------------------
	logic ctrl_en;
	logic [2:0] ctrl_mode;
	logic [15:0] thresh;
	logic [1:0] sel_ch;
	logic [15:0] sel_num;
	logic cap_done_q, start_req, go, wr_hit;
	rpd_state_e state;
	logic [15:0] rd_i, len;
	rpd_smp_s mem [DEPTH];
	rpd_smp_s cur, nxt;
	logic lead_bnd, tail, fast;
	logic [31:0] res_idx [`RPD_NCH][MAXP];
	logic [31:0] res_num [`RPD_NCH][MAXP];
	logic [15:0] res_den [`RPD_NCH][MAXP];
	logic [15:0] res_val [`RPD_NCH][MAXP];
	logic [15:0] cnt [`RPD_NCH];
	logic [15:0] avg [`RPD_NCH];
	logic [15:0] thr [`RPD_NCH];
	logic [15:0] mx [`RPD_NCH];
	logic [15:0] mn [`RPD_NCH];
	logic act [`RPD_NCH];
	logic lead [`RPD_NCH];
	logic [15:0] n [`RPD_NCH];
	logic [31:0] sum [`RPD_NCH];
	logic [15:0] first [`RPD_NCH];
	logic [15:0] prev [`RPD_NCH];
	logic [15:0] pmx [`RPD_NCH];
	logic [15:0] st [`RPD_NCH];
	logic above [`RPD_NCH];
	logic cl_go [`RPD_NCH];
	logic [15:0] cl_st [`RPD_NCH];
	rpd_close_s cl [`RPD_NCH];
	logic [1:0] cc;
	logic [15:0] pc;
	logic pa;
	logic [31:0] acc;
	logic dv_load;
	logic [31:0] dv_ld_num, dv_num, dv_quo;
	logic [15:0] dv_ld_den, dv_den;
	logic [32:0] dv_rem, dv_try, dv_sub;
	logic [5:0] dv_cnt;
	logic dv_done;
	logic [31:0] next_rdata;

	// ---------------------------------------------------------------
	// capture buffer
	// ---------------------------------------------------------------
	// a new waveform restarts the write pointer; samples beyond DEPTH are dropped
	always_ff @(posedge i_ref_clk) begin
		if (i_cap.valid && (i_cap.wave_first || len < DEPTH_W)) begin
			mem[i_cap.wave_first ? '0 : len[MAW-1:0]] <= i_cap.smp;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			len <= 16'h0000;
		end else if (i_cap.valid && i_cap.wave_first) begin
			len <= 16'h0001;
		end else if (i_cap.valid && len < DEPTH_W) begin
			len <= len + 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// register slave
	// ---------------------------------------------------------------
	// every request is answered one cycle after it appears
	assign wr_hit = i_avs.write && !o_avs_waitrequest;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h00000000;
		end else begin
			o_avs_waitrequest <= !(o_avs_waitrequest && (i_avs.read || i_avs.write));
			if (o_avs_waitrequest && i_avs.read) begin
				o_avs_readdata <= next_rdata;
			end
		end
	end
	// software settings; threshold resets to zero, the half-range default
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_en <= 1'b0;
			ctrl_mode <= 3'h0;
			thresh <= `RPD_THRESH_RST;
			sel_ch <= 2'h0;
			sel_num <= 16'h0000;
		end else if (wr_hit) begin
			case (i_avs.address)
				`RPD_REG_CTRL: begin
					ctrl_en <= i_avs.writedata[`RPD_CTRL_EN];
					ctrl_mode <= i_avs.writedata[`RPD_CTRL_MODE_HI:`RPD_CTRL_MODE_LO];
				end
				`RPD_REG_THRESH: thresh <= i_avs.writedata[15:0];
				`RPD_REG_SEL: begin
					sel_ch <= i_avs.writedata[`RPD_SEL_CH_HI:0];
					sel_num <= i_avs.writedata[31:`RPD_SEL_NUM_LO];
				end
				default: ;
			endcase
		end
	end
	// read mux; a disabled block reads cleared results except the used threshold, never not-a-number
	always_comb begin
		next_rdata = 32'h00000000;
		case (i_avs.address)
			`RPD_REG_CTRL: next_rdata = {28'h0000000, ctrl_mode, ctrl_en};
			`RPD_REG_THRESH: next_rdata = {16'h0000, thresh};
			`RPD_REG_STATUS: next_rdata = {29'h00000000, i_capture_done, o_results_valid, o_busy};
			`RPD_REG_SEL: next_rdata = {sel_num, 14'h0000, sel_ch};
			`RPD_REG_COUNT: next_rdata = {16'h0000, cnt[sel_ch]};
			`RPD_REG_PIDX: begin
				if (ctrl_en) begin
					next_rdata = (o_results_valid && sel_num < cnt[sel_ch]) ?
						res_idx[sel_ch][sel_num[PW-1:0]] : `RPD_NAN;
				end
			end
			`RPD_REG_PVAL: begin
				if (ctrl_en) begin
					next_rdata = (o_results_valid && sel_num < cnt[sel_ch]) ?
						{16'h0000, res_val[sel_ch][sel_num[PW-1:0]]} : `RPD_NAN;
				end
			end
			`RPD_REG_AVG: begin
				if (ctrl_en) begin
					next_rdata = (o_results_valid && cnt[sel_ch] != 16'h0000) ?
						{16'h0000, avg[sel_ch]} : `RPD_NAN;
				end
			end
			`RPD_REG_THR_USED: next_rdata = {16'h0000, thr[sel_ch]};
			default: next_rdata = 32'h00000000;
		endcase
	end

	// ---------------------------------------------------------------
	// evaluation requests
	// ---------------------------------------------------------------
	// a new frame, a changed threshold or enabling asks for a pass; set beats take
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cap_done_q <= 1'b0;
			start_req <= 1'b0;
		end else begin
			cap_done_q <= i_capture_done;
			start_req <= (i_capture_done && !cap_done_q) ||
				(wr_hit && i_avs.address == `RPD_REG_THRESH && i_avs.writedata[15:0] != thresh) ||
				(wr_hit && i_avs.address == `RPD_REG_CTRL && i_avs.writedata[`RPD_CTRL_EN] && !ctrl_en) ||
				(start_req && state != ST_IDLE);
		end
	end
	// a request without a complete capture is dropped, the last frame stays
	assign go = state == ST_IDLE && start_req && i_capture_done && ctrl_en && len != 16'h0000;
	property p_thr_retrig;
		wr_hit && i_avs.address == `RPD_REG_THRESH && i_avs.writedata[15:0] != thresh
			|=> start_req;
	endproperty
	a_thr_retrig: assert property (p_thr_retrig) else $error("threshold change lost");
	property p_no_capture;
		state == ST_IDLE && start_req && !i_capture_done |=> state == ST_IDLE;
	endproperty
	a_no_capture: assert property (p_no_capture) else $error("pass without capture");

	// ---------------------------------------------------------------
	// threshold: one setting for every channel, midpoint when zero
	// ---------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int c = 0; c < `RPD_NCH; c++) begin
				mx[c] <= 16'h0000;
				mn[c] <= 16'hFFFF;
				thr[c] <= 16'h0000;
			end
		end else if (go) begin
			for (int c = 0; c < `RPD_NCH; c++) begin
				mx[c] <= 16'h0000;
				mn[c] <= 16'hFFFF;
			end
		end else if (state == ST_MINMAX) begin
			for (int c = 0; c < `RPD_NCH; c++) begin
				if (rd_i < len) begin
					mx[c] <= f_max(mx[c], cur.ch[c]);
					mn[c] <= (cur.ch[c] < mn[c]) ? cur.ch[c] : mn[c];
				end else begin
					thr[c] <= (thresh == 16'h0000) ? f_mid(mx[c], mn[c]) : thresh;
				end
			end
		end
	end
	property p_thr_mid;
		state == ST_MINMAX && rd_i == len && thresh == 16'h0000
			|=> thr[0] == f_mid(mx[0], mn[0]);
	endproperty
	a_thr_mid: assert property (p_thr_mid) else $error("midpoint threshold wrong");
	property p_thr_shared;
		state == ST_MINMAX && rd_i == len && thresh != 16'h0000
			|=> thr[0] == $past(thresh) && thr[1] == thr[0] &&
			thr[2] == thr[0] && thr[3] == thr[0];
	endproperty
	a_thr_shared: assert property (p_thr_shared) else $error("threshold not shared");

	// ---------------------------------------------------------------
	// pulse scan, all channels in parallel
	// ---------------------------------------------------------------
	// frame edges only cut pulses in the fast modes
	always_comb begin
		cur = mem[rd_i[MAW-1:0]];
		nxt = mem[MAW'(rd_i + 16'h0001)];
		fast = ctrl_mode[`RPD_MODE_FAST];
		lead_bnd = rd_i == 16'h0000 || (fast && cur.frame_first);
		tail = rd_i == len - 16'h0001 || (fast && nxt.frame_first);
		for (int c = 0; c < `RPD_NCH; c++) begin
			above[c] = cur.ch[c] > thr[c];
			cl[c] = f_close(n[c], sum[c], first[c], prev[c], pmx[c], lead[c], 1'b0,
				fast ? MINW_FAST : MINW_SLOW);
			cl_st[c] = st[c];
			cl_go[c] = 1'b0;
			if (state == ST_SCAN && act[c] && !above[c]) begin
				cl_go[c] = cl[c].ok;
			end else if (state == ST_SCAN && above[c] && tail) begin
				cl[c] = f_close(act[c] ? n[c] + 16'h0001 : 16'h0001,
					act[c] ? sum[c] + {16'h0000, cur.ch[c]} : {16'h0000, cur.ch[c]},
					act[c] ? first[c] : cur.ch[c], cur.ch[c], pmx[c],
					act[c] ? lead[c] : lead_bnd, 1'b1, MINW_SLOW);
				cl_st[c] = act[c] ? st[c] : rd_i;
				cl_go[c] = cl[c].ok;
			end
		end
	end
	// open pulses; a pulse cut by the end of data is closed with its last sample
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int c = 0; c < `RPD_NCH; c++) begin
				act[c] <= 1'b0;
				lead[c] <= 1'b0;
				n[c] <= 16'h0000;
				sum[c] <= 32'h00000000;
				first[c] <= 16'h0000;
				prev[c] <= 16'h0000;
				pmx[c] <= 16'h0000;
				st[c] <= 16'h0000;
				cnt[c] <= 16'h0000;
			end
		end else if (!ctrl_en || go) begin
			for (int c = 0; c < `RPD_NCH; c++) begin
				act[c] <= 1'b0;
				cnt[c] <= 16'h0000;
			end
		end else if (state == ST_SCAN) begin
			for (int c = 0; c < `RPD_NCH; c++) begin
				act[c] <= above[c] && !tail;
				prev[c] <= cur.ch[c];
				if (above[c]) begin
					n[c] <= act[c] ? n[c] + 16'h0001 : 16'h0001;
					sum[c] <= act[c] ? sum[c] + {16'h0000, cur.ch[c]} : {16'h0000, cur.ch[c]};
					first[c] <= act[c] ? first[c] : cur.ch[c];
					lead[c] <= act[c] ? lead[c] : lead_bnd;
					st[c] <= act[c] ? st[c] : rd_i;
					pmx[c] <= !act[c] ? cur.ch[c] : (n[c] == 16'h0001) ? f_max(pmx[c], cur.ch[c]) : pmx[c];
				end
				if (cl_go[c] && cnt[c] < MAXP_W) begin
					cnt[c] <= cnt[c] + 16'h0001;
				end
			end
		end
	end
	// pulse records, numbered from zero in order of appearance
	always_ff @(posedge i_ref_clk) begin
		for (int c = 0; c < `RPD_NCH; c++) begin
			if (state == ST_SCAN && ctrl_en && cl_go[c] && cnt[c] < MAXP_W) begin
				res_idx[c][cnt[c][PW-1:0]] <= {16'h0000, cl_st[c]} - {16'h0000, i_trig_pos};
				res_num[c][cnt[c][PW-1:0]] <= cl[c].num;
				res_den[c][cnt[c][PW-1:0]] <= cl[c].den;
			end
			// the average divide must not land in a record slot, even when the count is full
			if (dv_done && !pa && pc < cnt[c] && 32'(c) == 32'(cc)) begin
				res_val[c][pc[PW-1:0]] <= dv_quo[15:0];
			end
		end
	end
	property p_start_idx;
		state == ST_SCAN && ctrl_en && above[0] && !act[0] |=> st[0] == $past(rd_i);
	endproperty
	a_start_idx: assert property (p_start_idx) else $error("pulse start index wrong");
	property p_strict;
		state == ST_SCAN && ctrl_en && !act[0] && cur.ch[0] == thr[0] |=> !act[0];
	endproperty
	a_strict: assert property (p_strict) else $error("pulse opened at threshold");
	property p_dis_clear;
		$fell(ctrl_en) |=> cnt[0] == 16'h0000 && cnt[3] == 16'h0000;
	endproperty
	a_dis_clear: assert property (p_dis_clear) else $error("counts kept when off");

	// ---------------------------------------------------------------
	// sequencer: minmax, scan, then one divide per pulse and per average
	// ---------------------------------------------------------------
	always_comb begin
		dv_load = 1'b0;
		dv_ld_num = acc;
		dv_ld_den = cnt[cc];
		if (state == ST_POST && !pa && pc < cnt[cc]) begin
			dv_load = 1'b1;
			dv_ld_num = res_num[cc][pc[PW-1:0]];
			dv_ld_den = res_den[cc][pc[PW-1:0]];
		end else if (state == ST_POST && !pa && cnt[cc] != 16'h0000) begin
			dv_load = 1'b1;
		end
	end
	assign dv_done = state == ST_DIVIDE && dv_cnt == `RPD_DIV_STEPS;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			rd_i <= 16'h0000;
			o_busy <= 1'b0;
			o_results_valid <= 1'b0;
			cc <= 2'h0;
			pc <= 16'h0000;
			pa <= 1'b0;
			acc <= 32'h00000000;
			for (int c = 0; c < `RPD_NCH; c++) begin
				avg[c] <= 16'h0000;
			end
		end else if (!ctrl_en || (i_cap.valid && i_cap.wave_first)) begin
			state <= ST_IDLE;
			o_busy <= 1'b0;
			o_results_valid <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (go) begin
						state <= ST_MINMAX;
						rd_i <= 16'h0000;
						o_busy <= 1'b1;
						o_results_valid <= 1'b0;
					end
				end
				ST_MINMAX: begin
					rd_i <= (rd_i == len) ? 16'h0000 : rd_i + 16'h0001;
					state <= (rd_i == len) ? ST_SCAN : ST_MINMAX;
				end
				ST_SCAN: begin
					rd_i <= rd_i + 16'h0001;
					if (rd_i == len - 16'h0001) begin
						state <= ST_POST;
						cc <= 2'h0;
						pc <= 16'h0000;
						pa <= 1'b0;
						acc <= 32'h00000000;
					end
				end
				ST_POST: begin
					if (dv_load) begin
						state <= ST_DIVIDE;
					end else if (cc == 2'h3) begin
						state <= ST_IDLE;
						o_busy <= 1'b0;
						o_results_valid <= 1'b1;
					end else begin
						cc <= cc + 2'h1;
						pc <= 16'h0000;
						pa <= 1'b0;
						acc <= 32'h00000000;
					end
				end
				ST_DIVIDE: begin
					if (dv_done) begin
						state <= ST_POST;
						if (pa || pc >= cnt[cc]) begin
							avg[cc] <= dv_quo[15:0];
							pa <= 1'b1;
						end else begin
							acc <= acc + {16'h0000, dv_quo[15:0]};
							pc <= pc + 16'h0001;
						end
					end
				end
			endcase
		end
	end
	property p_avg_nan;
		o_avs_waitrequest && i_avs.read && i_avs.address == `RPD_REG_AVG && ctrl_en &&
			cnt[sel_ch] == 16'h0000 |=> o_avs_readdata == `RPD_NAN;
	endproperty
	a_avg_nan: assert property (p_avg_nan) else $error("empty average not NaN");
	property p_sel_nan;
		o_avs_waitrequest && i_avs.read && i_avs.address == `RPD_REG_PIDX && ctrl_en &&
			o_results_valid && sel_num >= cnt[sel_ch] |=> o_avs_readdata == `RPD_NAN;
	endproperty
	a_sel_nan: assert property (p_sel_nan) else $error("bad pulse number not NaN");

	// ---------------------------------------------------------------
	// restoring divider, one quotient bit per cycle
	// ---------------------------------------------------------------
	always_comb begin
		dv_try = {dv_rem[31:0], dv_quo[31]};
		dv_sub = dv_try - {17'h00000, dv_den};
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dv_rem <= 33'h000000000;
			dv_quo <= 32'h00000000;
			dv_num <= 32'h00000000;
			dv_den <= 16'h0001;
			dv_cnt <= 6'h00;
		end else if (dv_load) begin
			dv_rem <= 33'h000000000;
			dv_quo <= dv_ld_num;
			dv_num <= dv_ld_num;
			dv_den <= dv_ld_den;
			dv_cnt <= 6'h00;
		end else if (state == ST_DIVIDE && !dv_done) begin
			dv_rem <= dv_sub[32] ? dv_try : dv_sub;
			dv_quo <= {dv_quo[30:0], !dv_sub[32]};
			dv_cnt <= dv_cnt + 6'h01;
		end
	end
	property p_div_exact;
		dv_done |-> 48'(dv_quo) * 48'(dv_den) + 48'(dv_rem) == 48'(dv_num);
	endproperty
	a_div_exact: assert property (p_div_exact) else $error("division wrong");

	c_pulse: cover property (state == ST_SCAN && cl_go[3]);
	c_trail: cover property (state == ST_SCAN && above[3] && tail && cl_go[3]);
	c_avg: cover property (dv_done && pa);
	c_done: cover property ($rose(o_results_valid));
endmodule
`default_nettype wire

// *** rpd_tb.sv ***
// rpd_tb.sv: self-checking bench of the radar pulse detector
`timescale 1ns/100ps
`default_nettype none
`include "rpd_cfg.svh"
module testbench;
	import rpd_pkg::*;
	localparam int N = 40;
	localparam int FB = 20;
	logic clk, rst_n, done, wreq, busy, valid;
	logic [15:0] tp;
	logic [31:0] rdat, d;
	rpd_cap_s cap;
	rpd_avs_req_s req;
	int n_fail, compares, fast, s[4][N], ei[$], ev[$];
	// pulse start and length per channel; frame edge at FB cuts ch1 only in fast modes
	int pt[4][6] = '{'{0, 3, 10, 6, 30, 4}, '{5, 5, 17, 6, 0, 0}, '{0, 0, 0, 0, 0, 0},
		'{12, 7, 35, 5, 0, 0}};
	rpd_radar_pulse_detector #(.SMP_NS_SLOW(500), .SMP_NS_FAST(125)) i_rpd_radar_pulse_detector (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_avs(req), .o_avs_waitrequest(wreq),
		.o_avs_readdata(rdat), .i_cap(cap), .i_capture_done(done), .i_trig_pos(tp),
		.o_busy(busy), .o_results_valid(valid));
	rpd_host_model i_rpd_host_model (.i_ref_clk(clk), .i_wait(wreq), .i_rdata(rdat), .o_req(req));
	// ----------------------------------------
	// clock, helpers and reference model
	// ----------------------------------------
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task conclude;
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] v);
		i_rpd_host_model.xfer(1'b1, a, v, d);
	endtask
	task rd(input logic [5:0] a);
		i_rpd_host_model.xfer(1'b0, a, 32'h0, d);
	endtask
	// noise at or below the threshold, so equality must not open a pulse
	task wave(input int t);
		rpd_cap_s v;
		for (int i = 0; i < N; i++) begin
			for (int c = 0; c < 4; c++) begin
				s[c][i] = $urandom_range(t);
				for (int k = 0; k < 6; k += 2)
					if (i >= pt[c][k] && i < pt[c][k] + pt[c][k+1]) s[c][i] = t + 1 + $urandom_range(999);
				v.smp.ch[c] = s[c][i][15:0];
			end
			v.valid = 1'b1;
			v.wave_first = i == 0;
			v.smp.frame_first = i == 0 || i == FB;
			@(posedge clk);
			cap <= v;
		end
		@(posedge clk);
		cap <= '0;
	endtask
	// expected pulses of one channel; cut pulses skip the width filter
	task model(input int c, input int t);
		int i, j, k, sum, ld, tl, mw;
		ei = {};
		ev = {};
		i = 0;
		mw = fast ? `RPD_T_MIN_FAST_NS / 125 + 1 : `RPD_T_MIN_SLOW_NS / 500 + 1;
		while (i < N) begin
			if (s[c][i] > t) begin
				j = i + 1;
				while (j < N && s[c][j] > t && !(fast && j == FB)) j++;
				ld = i == 0 || (fast && i == FB);
				tl = j == N || (fast && j == FB);
				sum = 0;
				if ((ld || tl) && j - i >= 2) begin
					for (k = ld ? i : i + 1; k < (ld ? j - 1 : j); k++) sum += s[c][k];
					ei.push_back(i - tp);
					ev.push_back(sum / (j - i - 1));
				end else if (!ld && !tl && j - i >= mw) begin
					for (k = i + 1; k < j - 1; k++) sum += s[c][k];
					ei.push_back(i - tp);
					ev.push_back(sum / (j - i - 2));
				end
				i = j;
			end else i++;
		end
	endtask
	// wait for a pass: valid drops first when a fresh pass is pending
	task settle;
		int k;
		k = 0;
		do begin rd(`RPD_REG_STATUS); k++; end while (d[1] && k < 500);
		do begin rd(`RPD_REG_STATUS); k++; end while (!(d[1] && !d[0]) && k < 3000);
		chk({30'h0, valid, busy}, 32'h2);
		if (k >= 3000) begin
			n_fail++;
			$display("BAD %0t no result", $time);
		end
	endtask
	task check(input int t);
		int u, a, mx, mn;
		for (int c = 0; c < 4; c++) begin
			u = t;
			if (t == 0) begin
				mx = 0;
				mn = 65535;
				for (int i = 0; i < N; i++) begin
					if (s[c][i] > mx) mx = s[c][i];
					if (s[c][i] < mn) mn = s[c][i];
				end
				u = (mx + mn) / 2;
			end
			model(c, u);
			wr(`RPD_REG_SEL, c);
			rd(`RPD_REG_COUNT); chk(d, ei.size());
			rd(`RPD_REG_THR_USED); chk(d, u);
			a = 0;
			for (int p = 0; p <= ei.size(); p++) begin
				wr(`RPD_REG_SEL, {p[15:0], 14'h0000, c[1:0]});
				rd(`RPD_REG_PIDX); chk(d, p < ei.size() ? ei[p] : `RPD_NAN);
				rd(`RPD_REG_PVAL); chk(d, p < ei.size() ? ev[p] : `RPD_NAN);
				if (p < ei.size()) a += ev[p];
			end
			rd(`RPD_REG_AVG); chk(d, ei.size() ? a / ei.size() : `RPD_NAN);
		end
	endtask
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		int t;
		void'($urandom(32'hFAB1));
		rst_n = 0;
		done = 0;
		cap = '0;
		tp = 16'h0007;
		fast = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rd(`RPD_REG_CTRL); chk(d, 32'h0);
		rd(`RPD_REG_THRESH); chk(d, `RPD_THRESH_RST);
		wr(6'h3C, 32'hFFFFFFFF);
		rd(6'h3C); chk(d, 32'h0);
		wr(`RPD_REG_COUNT, 32'h00000055);
		rd(`RPD_REG_COUNT); chk(d, 32'h0);
		t = 256 + $urandom_range(511);
		// mode 0 then mode 4; odd modes stay unused
		for (int m = 0; m < 2; m++) begin
			fast = m;
			wr(`RPD_REG_THRESH, t + m);
			wr(`RPD_REG_CTRL, {28'h0, m[0], 3'b001});
			wave(t + m);
			done <= 1;
			settle;
			check(t + m);
			wr(`RPD_REG_THRESH, t + m + 300);
			settle;
			check(t + m + 300);
			wr(`RPD_REG_THRESH, 0);
			settle;
			check(0);
			done <= 0;
		end
		wr(`RPD_REG_CTRL, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(`RPD_REG_SEL, c);
			rd(`RPD_REG_COUNT); chk(d, 32'h0);
			rd(`RPD_REG_PVAL); chk(d, 32'h0);
			rd(`RPD_REG_PIDX); chk(d, 32'h0);
			rd(`RPD_REG_AVG); chk(d, 32'h0);
		end
		conclude;
	end
	// a hang costs far more than the whole run should take
	initial begin
		#1000000;
		n_fail++;
		conclude;
	end
endmodule
`default_nettype wire
